// [src/frame_cfg_map.svh]
`ifndef FRAME_CFG_MAP_SVH
`define FRAME_CFG_MAP_SVH
`define OFS_FRAME_CTRL 8'h00
`define OFS_AUX_CTRL 8'h04
`define OFS_BAUD_DIV 8'h08
`define OFS_STATUS 8'h0C
`define OFS_DATA 8'h10
`define FC_PARITY_ODD 0
`define FC_PARITY_EN 1
`define FC_IDLE_START 2
`define FC_ROUSE 3
`define FC_NINE 4
`define AUX_BIT_ORDER 0
`define AUX_TEN_BIT 1
`define AUX_STANDBY 2
`define AUX_SMART_CARD 3
`define ST_RX_FULL 0
`define ST_PARITY_ERR 1
`define ST_IDLE 2
`define ST_TX_BUSY 3
`define ST_STANDBY 4
`define FRAME_CTRL_RESET 5'h00
`define AUX_CTRL_RESET 4'h0
`define BAUD_DIV_RESET 16'h0010
`define CHAR_BASE_BITS 4'h8
`define FRAME_OVERHEAD 4'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [src/frame_cfg_pkg.sv]
`include "frame_cfg_map.svh"
package frame_cfg_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } rx_state_e;
    typedef logic [15:0] baud_div_t;

    // Character width: data plus parity, 8 to 10 bits.
    function automatic logic [3:0] char_bits(input logic nine, input logic ten, input logic parity_enable);
        return `CHAR_BASE_BITS + {3'h0, nine} + {3'h0, nine & ten & parity_enable};
    endfunction

    // Parity over the low n bits, odd selects odd parity.
    function automatic logic parity_of(input logic [9:0] d, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 10; i++) begin
            if (i < int'(n)) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

    // Mirrors the low n bits.
    function automatic logic [9:0] reverse_bits(input logic [9:0] d, input logic [3:0] n);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 0; i < 10; i++) begin
            if (i < int'(n)) begin
                r[i] = d[int'(n) - 1 - i];
            end
        end
        return r;
    endfunction
endpackage

// [src/rx_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if;
    import frame_cfg_pkg::*;
    logic ce;
    logic rx;
    logic nine;
    logic ten;
    logic parity_enable;
    logic odd;
    logic bit_order_select;
    logic count_after_stop;
    baud_div_t div;
    logic valid;
    logic perr;
    logic mark;
    logic idle;
    logic [8:0] data;
    modport ctl (output ce, rx, nine, ten, parity_enable, odd, bit_order_select, count_after_stop, div,
        input valid, perr, mark, idle, data);
    modport eng (input ce, rx, nine, ten, parity_enable, odd, bit_order_select, count_after_stop, div,
        output valid, perr, mark, idle, data);
endinterface
`default_nettype wire

// [src/serial_rx_engine.sv]
`timescale 1ns/1ps
`default_nettype none
`include "frame_cfg_map.svh"
module serial_rx_engine
    import frame_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    rx_link_if.eng lk
);
    rx_state_e st_ff, nxt_st;
    logic [15:0] tim_ff, nxt_tim;
    logic [3:0] idx_ff, nxt_idx;
    logic [9:0] sh_ff, nxt_sh;
    logic [3:0] ones_ff, nxt_ones;
    logic seen_ff, nxt_seen;
    logic valid_ff, nxt_valid;
    logic perr_ff, nxt_perr;
    logic mark_ff, nxt_mark;
    logic idle_ff, nxt_idle;
    logic [8:0] data_ff, nxt_data;
    logic [3:0] cbits, dlen, flen;
    logic [9:0] dat, ord;
    logic tick, smp, stop_smp;
    logic [15:0] reload;

    assign cbits = char_bits(lk.nine, lk.ten, lk.parity_enable);
    assign dlen = cbits - {3'h0, lk.parity_enable};
    assign flen = cbits + `FRAME_OVERHEAD;
    assign dat = sh_ff & ~(10'h3FF << dlen);
    assign ord = lk.bit_order_select ? reverse_bits(dat, dlen) : dat;
    assign tick = (tim_ff == 16'h0000);
    assign reload = lk.div - 16'h0001;
    assign stop_smp = (st_ff == RX_BITS) && tick && (idx_ff == cbits);
    assign lk.valid = valid_ff;
    assign lk.perr = perr_ff;
    assign lk.mark = mark_ff;
    assign lk.idle = idle_ff;
    assign lk.data = data_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_tim = tim_ff;
        nxt_idx = idx_ff;
        nxt_sh = sh_ff;
        nxt_ones = ones_ff;
        nxt_seen = seen_ff;
        nxt_valid = 1'b0;
        nxt_idle = 1'b0;
        nxt_perr = perr_ff;
        nxt_mark = mark_ff;
        nxt_data = data_ff;
        smp = 1'b0;
        if (!tick) begin
            nxt_tim = tim_ff - 16'h0001;
        end
        case (st_ff)
            RX_IDLE: begin
                if (!lk.rx) begin
                    nxt_st = RX_START;
                    nxt_tim = lk.div >> 1;
                end else if (tick) begin
                    nxt_tim = reload;
                    smp = 1'b1;
                end
            end
            RX_START: begin
                if (tick) begin
                    nxt_tim = reload;
                    nxt_st = lk.rx ? RX_IDLE : RX_BITS;
                    if (!lk.rx) begin
                        nxt_idx = 4'h0;
                        nxt_ones = 4'h0;
                        nxt_seen = 1'b0;
                    end
                end
            end
            RX_BITS: begin
                if (tick) begin
                    nxt_tim = reload;
                    if (idx_ff == cbits) begin
                        nxt_st = RX_IDLE;
                        nxt_valid = 1'b1;
                        nxt_data = ord[8:0];
                        nxt_perr = lk.parity_enable & (sh_ff[dlen] != parity_of(dat, dlen, lk.odd));
                        nxt_mark = ord[dlen - 4'h1];
                        if (lk.count_after_stop) begin
                            nxt_ones = 4'h0;
                            nxt_seen = 1'b0;
                        end else begin
                            smp = 1'b1;
                        end
                    end else begin
                        nxt_sh[idx_ff] = lk.rx;
                        nxt_idx = idx_ff + 4'h1;
                        smp = !lk.count_after_stop;
                    end
                end
            end
            default: begin
                nxt_st = RX_IDLE;
            end
        endcase
        if (smp) begin
            if (!lk.rx) begin
                nxt_ones = 4'h0;
                nxt_seen = 1'b0;
            end else if (ones_ff != flen) begin
                nxt_ones = ones_ff + 4'h1;
                if ((ones_ff + 4'h1 == flen) && !seen_ff) begin
                    nxt_idle = 1'b1;
                    nxt_seen = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= RX_IDLE;
            tim_ff <= 16'h0000;
            idx_ff <= 4'h0;
            sh_ff <= 10'h000;
            ones_ff <= 4'h0;
            seen_ff <= 1'b0;
            valid_ff <= 1'b0;
            perr_ff <= 1'b0;
            mark_ff <= 1'b0;
            idle_ff <= 1'b0;
            data_ff <= 9'h000;
        end else if (lk.ce) begin
            st_ff <= nxt_st;
            tim_ff <= nxt_tim;
            idx_ff <= nxt_idx;
            sh_ff <= nxt_sh;
            ones_ff <= nxt_ones;
            seen_ff <= nxt_seen;
            valid_ff <= nxt_valid;
            perr_ff <= nxt_perr;
            mark_ff <= nxt_mark;
            idle_ff <= nxt_idle;
            data_ff <= nxt_data;
        end
    end

    a_stop_zero_count: assert property (
        @(posedge clk) disable iff (!rst_n) (lk.ce && stop_smp && lk.count_after_stop) |=> (ones_ff == 4'h0))
        else $error("Idle count not restarted after stop bit.");
    a_frame_count_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_ff == RX_BITS && lk.count_after_stop && $stable(lk.count_after_stop) && $past(st_ff) == RX_BITS)
        |-> (ones_ff == 4'h0))
        else $error("Ones counted inside a frame after stop-bit start was chosen.");
    a_idle_run_len: assert property (
        @(posedge clk) disable iff (!rst_n) idle_ff |-> (ones_ff == flen && flen >= 4'hA && flen <= 4'hC))
        else $error("Idle reported on a wrong run of ones.");
endmodule
`default_nettype wire

// [src/frame_uart.sv]
// Functional notes
// - A frame is a start bit, 8 data bits (9 with the ninth-bit select), a stop bit, in the selected bit order.
// - In standby the receiver wakes on an idle line when rouse is 0, or on an address mark in the data MSB when 1.
// - Idle counting of ones starts after a valid start bit when idle_count_start is 0, after the stop bit when 1.
// - With idle_count_start set, the ones count is cleared when each stop bit is sampled, so the idle count restarts.
// - In standby with idle-line rouse, idle_count_start has no effect on when counting starts.
// - During idle-line rouse an idle character is a run of 10, 11 or 12 ones, set by ninth-bit, parity and ten-bit.
// - With parity on, the parity bit sits right before the stop bit on send and is checked there on receive.
// - Parity type 0 is even and 1 is odd, for generation and checking alike.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "frame_cfg_map.svh"
module frame_uart
    import frame_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    rx_link_if lk();

    logic rx_s1_ff, rx_s2_ff;
    logic [4:0] fc_ff, nxt_fc;
    logic [3:0] aux_ff, nxt_aux;
    logic [15:0] div_ff, nxt_div;
    logic full_ff, nxt_full;
    logic perr_ff, nxt_perr;
    logic idle_ff, nxt_idle;
    logic [8:0] rxd_ff, nxt_rxd;
    logic tx_ff, nxt_tx;
    logic [11:0] tsh_ff, nxt_tsh;
    logic [3:0] left_ff, nxt_left;
    logic [15:0] ttim_ff, nxt_ttim;
    logic awh_ff, nxt_awh;
    logic [7:0] awa_ff, nxt_awa;
    logic wh_ff, nxt_wh;
    logic [31:0] wd_ff, nxt_wd;
    logic [3:0] ws_ff, nxt_ws;
    logic awr_ff, nxt_awr;
    logic wr_ff, nxt_wr;
    logic bv_ff, nxt_bv;
    logic [1:0] br_ff, nxt_br;
    logic arr_ff, nxt_arr;
    logic rv_ff, nxt_rv;
    logic [31:0] rd_ff, nxt_rd;
    logic [1:0] rr_ff, nxt_rr;
    logic [7:0] wa;
    logic [31:0] wdv;
    logic [3:0] wsv;
    logic do_wr, do_rd, busy, standby, wake_addr, wake_idle;
    logic [3:0] cbits, dlen;
    logic [9:0] txd;
    logic [11:0] vec;

    assign tx_pin = tx_ff;
    assign awready = awr_ff;
    assign wready = wr_ff;
    assign bvalid = bv_ff;
    assign bresp = br_ff;
    assign arready = arr_ff;
    assign rvalid = rv_ff;
    assign rdata = rd_ff;
    assign rresp = rr_ff;

    assign lk.ce = ce;
    assign lk.rx = rx_s2_ff;
    assign lk.nine = fc_ff[`FC_NINE];
    assign lk.ten = aux_ff[`AUX_TEN_BIT];
    assign lk.parity_enable = fc_ff[`FC_PARITY_EN];
    assign lk.odd = fc_ff[`FC_PARITY_ODD];
    assign lk.bit_order_select = aux_ff[`AUX_BIT_ORDER];
    assign lk.div = div_ff;
    assign lk.count_after_stop = fc_ff[`FC_IDLE_START] & ~(aux_ff[`AUX_STANDBY] & ~fc_ff[`FC_ROUSE]);

    serial_rx_engine u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .lk(lk)
    );

    assign standby = aux_ff[`AUX_STANDBY];
    assign busy = (left_ff != 4'h0);
    assign cbits = char_bits(fc_ff[`FC_NINE], aux_ff[`AUX_TEN_BIT], fc_ff[`FC_PARITY_EN]);
    assign dlen = cbits - {3'h0, fc_ff[`FC_PARITY_EN]};
    assign wake_addr = standby & fc_ff[`FC_ROUSE] & lk.valid & lk.mark;
    assign wake_idle = standby & ~fc_ff[`FC_ROUSE] & lk.idle;
    assign wa = awh_ff ? awa_ff : awaddr;
    assign wdv = wh_ff ? wd_ff : wdata;
    assign wsv = wh_ff ? ws_ff : wstrb;
    assign do_wr = (awh_ff | (awvalid & awr_ff)) & (wh_ff | (wvalid & wr_ff)) & ~bv_ff;
    assign do_rd = arvalid & arr_ff;
    assign txd = aux_ff[`AUX_BIT_ORDER] ? reverse_bits({1'b0, wdv[8:0]}, dlen) : {1'b0, wdv[8:0]};

    always_comb begin
        vec = 12'hFFE;
        for (int i = 0; i < 10; i++) begin
            if (i < int'(dlen)) begin
                vec[i + 1] = txd[i];
            end
        end
        if (fc_ff[`FC_PARITY_EN]) begin
            vec[dlen + 4'h1] = parity_of(txd, dlen, fc_ff[`FC_PARITY_ODD]);
        end
    end

    always_comb begin
        nxt_fc = fc_ff;
        nxt_aux = aux_ff;
        nxt_div = div_ff;
        nxt_full = full_ff;
        nxt_perr = perr_ff;
        nxt_idle = idle_ff;
        nxt_rxd = rxd_ff;
        nxt_tx = tx_ff;
        nxt_tsh = tsh_ff;
        nxt_left = left_ff;
        nxt_ttim = ttim_ff;
        nxt_awh = awh_ff;
        nxt_awa = awa_ff;
        nxt_wh = wh_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (awvalid & awr_ff) begin
            nxt_awh = 1'b1;
            nxt_awa = awaddr;
        end
        if (wvalid & wr_ff) begin
            nxt_wh = 1'b1;
            nxt_wd = wdata;
            nxt_ws = wstrb;
        end
        if (bv_ff & bready) begin
            nxt_bv = 1'b0;
        end
        if (rv_ff & rready) begin
            nxt_rv = 1'b0;
        end
        if (busy) begin
            if (ttim_ff == 16'h0000) begin
                nxt_ttim = div_ff - 16'h0001;
                nxt_tsh = {1'b1, tsh_ff[11:1]};
                nxt_tx = tsh_ff[1];
                nxt_left = left_ff - 4'h1;
            end else begin
                nxt_ttim = ttim_ff - 16'h0001;
            end
        end
        if (do_wr) begin
            nxt_awh = 1'b0;
            nxt_wh = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = `RESP_OKAY;
            case (wa)
                `OFS_FRAME_CTRL: begin
                    nxt_fc = wsv[0] ? wdv[4:0] : fc_ff;
                end
                `OFS_AUX_CTRL: begin
                    nxt_aux = wsv[0] ? wdv[3:0] : aux_ff;
                end
                `OFS_BAUD_DIV: begin
                    nxt_div = {wsv[1] ? wdv[15:8] : div_ff[15:8], wsv[0] ? wdv[7:0] : div_ff[7:0]};
                end
                `OFS_STATUS: begin
                    nxt_perr = perr_ff & ~(wsv[0] & wdv[`ST_PARITY_ERR]);
                    nxt_idle = idle_ff & ~(wsv[0] & wdv[`ST_IDLE]);
                end
                `OFS_DATA: begin
                    if (wsv[0] && !busy) begin
                        nxt_tsh = vec;
                        nxt_tx = 1'b0;
                        nxt_left = cbits + `FRAME_OVERHEAD;
                        nxt_ttim = div_ff - 16'h0001;
                    end
                end
                default: begin
                    nxt_br = `RESP_SLVERR;
                end
            endcase
        end
        if (do_rd) begin
            nxt_rv = 1'b1;
            nxt_rr = `RESP_OKAY;
            case (araddr)
                `OFS_FRAME_CTRL: nxt_rd = {27'h0, fc_ff};
                `OFS_AUX_CTRL: nxt_rd = {28'h0, aux_ff};
                `OFS_BAUD_DIV: nxt_rd = {16'h0, div_ff};
                `OFS_STATUS: nxt_rd = {27'h0, standby, busy, idle_ff, perr_ff, full_ff};
                `OFS_DATA: begin
                    nxt_rd = {23'h0, rxd_ff};
                    nxt_full = 1'b0;
                end
                default: begin
                    nxt_rd = 32'h0000_0000;
                    nxt_rr = `RESP_SLVERR;
                end
            endcase
        end
        if (lk.valid && (!standby || wake_addr)) begin
            nxt_rxd = lk.data;
            nxt_full = 1'b1;
            nxt_perr = nxt_perr | lk.perr;
        end
        if (lk.idle && !standby) begin
            nxt_idle = 1'b1;
        end
        if (wake_addr || wake_idle) begin
            nxt_aux[`AUX_STANDBY] = 1'b0;
        end
        nxt_awr = ~nxt_awh & ~nxt_bv;
        nxt_wr = ~nxt_wh & ~nxt_bv;
        nxt_arr = ~nxt_rv;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else if (ce) begin
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fc_ff <= `FRAME_CTRL_RESET;
            aux_ff <= `AUX_CTRL_RESET;
            div_ff <= `BAUD_DIV_RESET;
            full_ff <= 1'b0;
            perr_ff <= 1'b0;
            idle_ff <= 1'b0;
            rxd_ff <= 9'h000;
            tx_ff <= 1'b1;
            tsh_ff <= 12'hFFF;
            left_ff <= 4'h0;
            ttim_ff <= 16'h0000;
            awh_ff <= 1'b0;
            awa_ff <= 8'h00;
            wh_ff <= 1'b0;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
            awr_ff <= 1'b1;
            wr_ff <= 1'b1;
            bv_ff <= 1'b0;
            br_ff <= 2'h0;
            arr_ff <= 1'b1;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
            rr_ff <= 2'h0;
        end else if (ce) begin
            fc_ff <= nxt_fc;
            aux_ff <= nxt_aux;
            div_ff <= nxt_div;
            full_ff <= nxt_full;
            perr_ff <= nxt_perr;
            idle_ff <= nxt_idle;
            rxd_ff <= nxt_rxd;
            tx_ff <= nxt_tx;
            tsh_ff <= nxt_tsh;
            left_ff <= nxt_left;
            ttim_ff <= nxt_ttim;
            awh_ff <= nxt_awh;
            awa_ff <= nxt_awa;
            wh_ff <= nxt_wh;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            awr_ff <= nxt_awr;
            wr_ff <= nxt_wr;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            arr_ff <= nxt_arr;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
        end
    end

    a_tx_frame_start: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(busy) |-> (!tx_ff && left_ff == cbits + `FRAME_OVERHEAD))
        else $error("Transmit frame started without start bit or with wrong length.");
    a_tx_stop_place: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(busy) |-> (tsh_ff[cbits + 4'h1] == 1'b1))
        else $error("Stop bit not right after the character.");
    a_tx_parity_val: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($rose(busy) && fc_ff[`FC_PARITY_EN])
        |-> (tsh_ff[dlen + 4'h1] == (^(tsh_ff[10:1] & ~(10'h3FF << dlen)) ^ fc_ff[`FC_PARITY_ODD])))
        else $error("Transmitted parity bit does not follow parity type.");
    a_addr_wake: assert property (
        @(posedge clk) disable iff (!rst_n) (ce && lk.valid && lk.mark && standby && fc_ff[`FC_ROUSE]) |=> !standby)
        else $error("Address mark did not wake the receiver.");
    a_idle_wake: assert property (
        @(posedge clk) disable iff (!rst_n) (ce && lk.idle && standby && !fc_ff[`FC_ROUSE]) |=> !standby)
        else $error("Idle line did not wake the receiver.");
    a_parity_flag: assert property (
        @(posedge clk) disable iff (!rst_n) (ce && lk.valid && lk.perr && !standby) |=> (perr_ff && full_ff))
        else $error("Parity error not flagged.");
endmodule
`default_nettype wire

// [sim/serial_node.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_node #(
    parameter int DIV = 8
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out,
    input wire logic [3:0] nbits
);
    logic [11:0] rx_word;
    int got;
    // Receives whole frames: start found on the fall, bits sampled mid-cell.
    initial begin
        line_out = 1'b1;
        got = 0;
        rx_word = 12'h000;
        forever begin
            @(negedge line_in);
            rx_word = 12'h000;
            repeat (DIV / 2) @(posedge clk);
            for (int i = 0; i < nbits; i++) begin
                rx_word[i] = line_in;
                if (i < nbits - 1) repeat (DIV) @(posedge clk);
            end
            got++;
        end
    end
    // Sends a frame, first bit in f[0], then returns the line to idle high.
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_out <= f[i];
            repeat (DIV) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [sim/tb_frame_uart.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_frame_uart;
    logic clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready, tx_pin, rx_pin;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, nb4;
    logic [1:0] bresp, rresp, resp;
    int mismatches, n_compared, seed, nb;
    frame_uart dut (.clk(clk), .rst_n(rst_n), .ce(ce), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    serial_node #(.DIV(8)) node (.clk(clk), .line_in(tx_pin), .line_out(rx_pin), .nbits(nb4));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                bready <= 1'b0;
                resp = bresp;
            end
        end
        if (!done) begin
            mismatches++;
            print_verdict();
        end
    endtask
    task automatic axr(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                rready <= 1'b0;
                rd = rdata;
                resp = rresp;
            end
        end
        if (!done) begin
            mismatches++;
            print_verdict();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        axr(a);
        `CHK(nm, e, rd)
    endtask
    // Builds the expected frame, first bit in bit 0, and its length.
    function automatic logic [11:0] mk(input logic [8:0] d, input logic [4:0] fc, input logic [3:0] ax,
                                       output int nb);
        int nd;
        logic p;
        logic [11:0] f;
        nd = 8 + fc[4] + (fc[4] & ax[1] & fc[1]) - fc[1];
        nb = nd + 2 + fc[1];
        p = fc[0];
        f = 12'h000;
        for (int i = 0; i < nd; i++) begin
            f[i + 1] = ax[0] ? d[nd - 1 - i] : d[i];
            p = p ^ d[i];
        end
        if (fc[1]) f[nd + 1] = p;
        f[nb - 1] = 1'b1;
        return f;
    endfunction
    initial begin
        logic [4:0] fc;
        logic [3:0] ax;
        logic [8:0] d;
        logic [11:0] f, g;
        int nd, g0;
        seed = 32'h00FC;
        mismatches = 0;
        n_compared = 0;
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, ce, wstrb, nb4} = {48'h0, 1'b1, 4'hF, 4'hA};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(8'h00, 32'h0, "frame ctrl reset");
        rchk(8'h08, 32'h10, "divisor reset");
        axr(8'h14);
        `CHK("unmapped resp", 2'h2, resp)
        axw(8'h08, 32'h8);
        $display("test registers done");
        for (int t = 0; t < 10; t++) begin
            fc = 5'($random(seed)) & 5'h17;
            ax = 4'($random(seed)) & 4'h3;
            d = 9'($random(seed));
            axw(8'h00, {27'h0, fc});
            axw(8'h04, {28'h0, ax});
            f = mk(d, fc, ax, nb);
            nb4 = nb[3:0];
            nd = nb - 2 - fc[1];
            g0 = node.got;
            axw(8'h10, {23'h0, d});
            for (int n = 0; n < 400 && node.got == g0; n++) @(posedge clk);
            if (node.got == g0) begin
                mismatches++;
                print_verdict();
            end
            `CHK("tx frame", f, node.rx_word)
            g = f;
            if (fc[1] && $random(seed) % 2 == 0) g[nb - 2] = ~g[nb - 2];
            node.send(g, nb);
            repeat (nb * 16 + 40) @(posedge clk);
            rchk(8'h0C, {29'h0, 1'b1, g != f, 1'b1}, "status");
            rchk(8'h10, {23'h0, d & (9'h1FF >> (9 - nd))}, "rx data");
            axw(8'h0C, 32'h6);
        end
        $display("test frames done");
        nb4 = 4'hA;
        axw(8'h00, 32'h08);
        axr(8'h10);
        axw(8'h04, 32'h4);
        for (int k = 0; k < 2; k++) begin
            f = mk({1'b0, k[0], 7'h12}, 5'h08, 4'h0, nb);
            node.send(f, nb);
            repeat (120) @(posedge clk);
            axr(8'h0C);
            `CHK("address wake", k ? 32'h01 : 32'h10, rd & 32'h11)
        end
        rchk(8'h10, 32'h92, "address char");
        axw(8'h00, 32'h04);
        axw(8'h04, 32'h4);
        f = mk(9'h0FF, 5'h04, 4'h0, nb);
        node.send(f, nb);
        repeat (24) @(posedge clk);
        axr(8'h0C);
        `CHK("idle wake", 32'h00, rd & 32'h11)
        $display("test standby done");
        for (int k = 0; k < 2; k++) begin
            axw(8'h00, {29'h0, k[0], 2'h0});
            axr(8'h10);
            axw(8'h0C, 32'h6);
            f = mk(9'h0FF, {2'h0, k[0], 2'h0}, 4'h0, nb);
            node.send(f, nb);
            repeat (24) @(posedge clk);
            axr(8'h0C);
            `CHK("idle start", ~k[0], rd[2])
        end
        $display("test idle start done");
        axr(8'h10);
        ce <= 1'b0;
        node.send(f, nb);
        ce <= 1'b1;
        repeat (24) @(posedge clk);
        axr(8'h0C);
        `CHK("frozen rx", 32'h0, rd & 32'h1)
        $display("test clock enable done");
        axw(8'h00, 32'h02);
        axw(8'h04, 32'h8);
        rchk(8'h04, 32'h8, "smart card");
        $display("test smart card done");
        print_verdict();
    end
endmodule
`default_nettype wire
